//--- hdl/lsd_config_regs.sv
/*
 lsd_config_regs: configuration and status register bank of a four-channel
 low-side driver, reached through decoded 16-bit serial frames.
 assumes FRAME_STB is a one-cycle pulse per complete frame, synchronous to MCLK,
 and that analog status inputs are already synchronous.
*/
// How it works
// - test current enable bit switches source on
// - reserved bits read zero, writes dropped
// - status bit one when voltage below threshold
// - active bit one enters active mode
// - reset bit runs logic reset, self clears
// - open-load disable bit turns detection off
// - profile bit selects second overcurrent profile
// - odd pairing bit couples channels one, three
// - even pairing bit couples channels zero, two
// - clear bit clears that channel's latched error
// - lock code locks all but lock, clear
// - unlocked, other lock codes do nothing
// - unlock code reopens all registers
// - locked, other lock codes do nothing
// - overtemperature warning reads one after event
// - slew bit selects fast or slow slew
// - fault flag shows latched overload or overtemperature
// - summary flag: enabled off channel below threshold
`timescale 1ns/1ps
module lsd_config_regs #(
    parameter int N_CH = 4
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic FRAME_STB,
    input wire lsd_pkg::lsd_frame_t FRAME,
    input wire logic [N_CH-1:0] VDS_BELOW_OL,
    input wire logic [N_CH-1:0] CH_ON,
    input wire logic [N_CH-1:0] FAULT_EVENT,
    input wire logic OVERTEMP_EVENT,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic [N_CH-1:0] TEST_CURRENT_EN,
    output logic ACTIVE_MODE_REQ,
    output logic LOGIC_RESET_CMD,
    output logic OL_DETECT_DIS,
    output logic OC_PROFILE_SEL,
    output logic PAIR_EVEN,
    output logic PAIR_ODD,
    output logic SLEW_SEL,
    output logic [N_CH-1:0] FAULT_FLAGS,
    output logic OL_SUMMARY,
    output logic OT_WARN_FLAG
);
    import lsd_pkg::*;

    logic [N_CH-1:0] src_en_reg;
    logic [N_CH-1:0] vds_reg;
    logic [N_CH-1:0] clr_reg;
    logic [N_CH-1:0] fault_reg;
    logic [N_CH-1:0] fault_set;
    logic act_reg;
    logic rst_cmd_reg;
    logic ol_dis_reg;
    logic oc_prof_reg;
    logic pair_odd_reg;
    logic pair_even_reg;
    logic slew_reg;
    logic locked_reg;
    logic ot_warn_reg;
    logic ol_sum_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic srst_all;
    logic wr;
    logic rd;
    logic wr_open;

    // reset command acts like the reset pin one cycle later
    assign srst_all = SRST | rst_cmd_reg;
    assign wr = FRAME_STB && (FRAME.cmd == CMD_WRITE);
    assign rd = FRAME_STB && (FRAME.cmd == CMD_READ);
    assign wr_open = wr && !locked_reg;

    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            src_en_reg <= RST_OL_SRC[N_CH-1:0];
        end else if (wr_open && FRAME.addr == ADDR_OL_SRC) begin
            // upper bits never stored
            src_en_reg <= FRAME.data[N_CH-1:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            act_reg <= RST_MAIN_CFG[BIT_ACT];
            ol_dis_reg <= RST_MAIN_CFG[BIT_OL_DIS];
            oc_prof_reg <= RST_MAIN_CFG[BIT_OC_PROF];
            pair_odd_reg <= RST_MAIN_CFG[BIT_PAIR_ODD];
            pair_even_reg <= RST_MAIN_CFG[BIT_PAIR_EVEN];
        end else if (wr_open && FRAME.addr == ADDR_MAIN_CFG) begin
            act_reg <= FRAME.data[BIT_ACT];
            ol_dis_reg <= FRAME.data[BIT_OL_DIS];
            oc_prof_reg <= FRAME.data[BIT_OC_PROF];
            pair_odd_reg <= FRAME.data[BIT_PAIR_ODD];
            pair_even_reg <= FRAME.data[BIT_PAIR_EVEN];
        end
    end

    // the !rst_cmd_reg term clears it the cycle after it sets, so the pulse lasts exactly one cycle;
    // a frame landing during the pulse is lost and must not retrigger it
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rst_cmd_reg <= 1'b0;
        end else begin
            rst_cmd_reg <= !rst_cmd_reg && wr_open && FRAME.addr == ADDR_MAIN_CFG && FRAME.data[BIT_RST];
        end
    end

    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            locked_reg <= 1'b0;
        end else if (wr && FRAME.addr == ADDR_LOCK_SLEW) begin
            // lock field passes even while locked, else nothing could unlock
            if (!locked_reg && FRAME.data[LOCK_MSB:LOCK_LSB] == LOCK_CODE) begin
                locked_reg <= 1'b1;
            end else if (locked_reg && FRAME.data[LOCK_MSB:LOCK_LSB] == UNLOCK_CODE) begin
                locked_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            slew_reg <= RST_LOCK_SLEW[BIT_SLEW];
        end else if (wr_open && FRAME.addr == ADDR_LOCK_SLEW) begin
            // a locked frame carrying the unlock code leaves slew alone
            slew_reg <= FRAME.data[BIT_SLEW];
        end
    end

    // clear bits accepted even when locked, held for one cycle only
    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            clr_reg <= RST_ERR_CLR[N_CH-1:0];
        end else if (wr && FRAME.addr == ADDR_ERR_CLR) begin
            clr_reg <= FRAME.data[N_CH-1:0];
        end else begin
            clr_reg <= '0;
        end
    end

    // paired channels latch together
    always_comb begin
        fault_set = FAULT_EVENT;
        if (pair_even_reg) begin
            fault_set[0] = FAULT_EVENT[0] | FAULT_EVENT[2];
            fault_set[2] = FAULT_EVENT[0] | FAULT_EVENT[2];
        end
        if (pair_odd_reg) begin
            fault_set[1] = FAULT_EVENT[1] | FAULT_EVENT[3];
            fault_set[3] = FAULT_EVENT[1] | FAULT_EVENT[3];
        end
    end

    // new event wins over a clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= (fault_reg & ~clr_reg) | fault_set;
        end
    end

    // sticky until a logic reset
    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            ot_warn_reg <= RST_LOCK_SLEW[BIT_OT_WARN];
        end else begin
            ot_warn_reg <= ot_warn_reg | OVERTEMP_EVENT;
        end
    end

    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            vds_reg <= '0;
            ol_sum_reg <= 1'b0;
        end else begin
            vds_reg <= VDS_BELOW_OL;
            // channels that are on cannot show open load
            ol_sum_reg <= |(~CH_ON & src_en_reg & VDS_BELOW_OL);
        end
    end

    always_comb begin
        rd_data_next = 8'h00;
        unique case (FRAME.addr)
            ADDR_OL_SRC: rd_data_next[N_CH-1:0] = src_en_reg;
            ADDR_OUT_STAT: rd_data_next[N_CH-1:0] = vds_reg;
            ADDR_MAIN_CFG: begin
                rd_data_next[BIT_ACT] = act_reg;
                rd_data_next[BIT_OL_DIS] = ol_dis_reg;
                rd_data_next[BIT_OC_PROF] = oc_prof_reg;
                rd_data_next[BIT_PAIR_ODD] = pair_odd_reg;
                rd_data_next[BIT_PAIR_EVEN] = pair_even_reg;
            end
            ADDR_ERR_CLR: rd_data_next[N_CH-1:0] = clr_reg;
            ADDR_LOCK_SLEW: begin
                rd_data_next[LOCK_MSB:LOCK_LSB] = locked_reg ? LOCK_CODE : UNLOCK_CODE;
                rd_data_next[BIT_OT_WARN] = ot_warn_reg;
                rd_data_next[BIT_SLEW] = slew_reg;
            end
            default: rd_data_next = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (srst_all) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd;
            if (rd) begin
                rd_data_reg <= rd_data_next;
            end
        end
    end

    assign RD_DATA = rd_data_reg;
    assign RD_VALID = rd_valid_reg;
    assign TEST_CURRENT_EN = src_en_reg;
    assign ACTIVE_MODE_REQ = act_reg;
    assign LOGIC_RESET_CMD = rst_cmd_reg;
    assign OL_DETECT_DIS = ol_dis_reg;
    assign OC_PROFILE_SEL = oc_prof_reg;
    assign PAIR_EVEN = pair_even_reg;
    assign PAIR_ODD = pair_odd_reg;
    assign SLEW_SEL = slew_reg;
    assign FAULT_FLAGS = fault_reg;
    assign OL_SUMMARY = ol_sum_reg;
    assign OT_WARN_FLAG = ot_warn_reg;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (srst_all);

    AST_SRC_EN: assert property (wr_open && FRAME.addr == ADDR_OL_SRC |=>
        TEST_CURRENT_EN == $past(FRAME.data[N_CH-1:0]))
        else $error("test current enables not loaded");
    AST_RSVD_ZERO: assert property (rd && FRAME.addr == ADDR_OL_SRC |=>
        RD_VALID && RD_DATA[7:N_CH] == '0)
        else $error("reserved bits read nonzero");
    AST_OUT_STAT: assert property (rd && FRAME.addr == ADDR_OUT_STAT |=>
        RD_DATA == {4'h0, $past(vds_reg)})
        else $error("output status read mismatch");
    AST_ACT: assert property (wr_open && FRAME.addr == ADDR_MAIN_CFG |=>
        ACTIVE_MODE_REQ == $past(FRAME.data[BIT_ACT]) && OL_DETECT_DIS == $past(FRAME.data[BIT_OL_DIS]))
        else $error("active or open-load disable not loaded");
    AST_RST_PULSE: assert property (disable iff (SRST)
        wr_open && FRAME.addr == ADDR_MAIN_CFG && FRAME.data[BIT_RST] |=>
        LOGIC_RESET_CMD ##1 (!LOGIC_RESET_CMD && !ACTIVE_MODE_REQ && !locked_reg))
        else $error("reset command not self clearing");
    AST_OC_PROF: assert property (wr_open && FRAME.addr == ADDR_MAIN_CFG |=>
        OC_PROFILE_SEL == $past(FRAME.data[BIT_OC_PROF]))
        else $error("profile select not loaded");
    AST_PAIR_ODD: assert property (PAIR_ODD && FAULT_EVENT[3] |=> FAULT_FLAGS[1])
        else $error("odd pair did not latch together");
    AST_PAIR_EVEN: assert property (PAIR_EVEN && FAULT_EVENT[0] |=> FAULT_FLAGS[2])
        else $error("even pair did not latch together");
    AST_CLR: assert property (wr && FRAME.addr == ADDR_ERR_CLR && FRAME.data[1]
        ##1 !fault_set[1] |=> !FAULT_FLAGS[1])
        else $error("error latch not cleared");
    AST_LOCK: assert property (!locked_reg && wr && FRAME.addr == ADDR_LOCK_SLEW
        && FRAME.data[LOCK_MSB:LOCK_LSB] == LOCK_CODE |=> locked_reg)
        else $error("lock code did not lock");
    AST_LOCKED_IGNORE: assert property (locked_reg && wr && FRAME.addr != ADDR_ERR_CLR
        |=> $stable(TEST_CURRENT_EN) && $stable(ACTIVE_MODE_REQ) && $stable(SLEW_SEL))
        else $error("write took effect while locked");
    AST_UNLOCKED_STAY: assert property (!locked_reg && wr && FRAME.addr == ADDR_LOCK_SLEW
        && FRAME.data[LOCK_MSB:LOCK_LSB] != LOCK_CODE |=> !locked_reg)
        else $error("non-lock code changed lock state");
    AST_UNLOCK: assert property (locked_reg && wr && FRAME.addr == ADDR_LOCK_SLEW
        && FRAME.data[LOCK_MSB:LOCK_LSB] == UNLOCK_CODE |=> !locked_reg)
        else $error("unlock code did not unlock");
    AST_LOCKED_STAY: assert property (locked_reg && wr && FRAME.addr == ADDR_LOCK_SLEW
        && FRAME.data[LOCK_MSB:LOCK_LSB] != UNLOCK_CODE |=> locked_reg)
        else $error("non-unlock code released lock");
    AST_OT_WARN: assert property (OVERTEMP_EVENT |=> OT_WARN_FLAG [*2])
        else $error("warning flag not sticky");
    AST_SLEW: assert property (wr_open && FRAME.addr == ADDR_LOCK_SLEW |=>
        SLEW_SEL == $past(FRAME.data[BIT_SLEW]))
        else $error("slew select not loaded");
    AST_FAULT: assert property (FAULT_EVENT[0] |=> FAULT_FLAGS[0])
        else $error("fault not latched");
    AST_OL_SUM: assert property (##1 OL_SUMMARY ==
        $past(|(~CH_ON & TEST_CURRENT_EN & VDS_BELOW_OL)))
        else $error("open-load summary wrong");
    AST_CLR_RETURN: assert property (!(wr && FRAME.addr == ADDR_ERR_CLR) |=> clr_reg == '0)
        else $error("clear bits did not return to zero");
    AST_READ: assert property (rd |=> RD_VALID ##1 (RD_VALID == $past(rd)))
        else $error("read answer timing wrong");

    // a logic reset in flight aborts these except AST_RST_CLEARS, which only SRST disables, so its one-cycle pulse stays quiet
    AST_OL_DIS: assert property (wr_open && FRAME.addr == ADDR_MAIN_CFG |=>
        OL_DETECT_DIS == $past(FRAME.data[BIT_OL_DIS]))
        else $error("open-load disable not loaded");
    AST_PAIR_BITS: assert property (wr_open && FRAME.addr == ADDR_MAIN_CFG |=>
        PAIR_ODD == $past(FRAME.data[BIT_PAIR_ODD]) && PAIR_EVEN == $past(FRAME.data[BIT_PAIR_EVEN]))
        else $error("pairing bits not loaded");
    AST_RST_READ: assert property (rd && FRAME.addr == ADDR_MAIN_CFG |=> !RD_DATA[BIT_RST])
        else $error("reset bit reads back set");
    AST_RST_CLEARS: assert property (disable iff (SRST) LOGIC_RESET_CMD |=>
        !OT_WARN_FLAG && TEST_CURRENT_EN == '0 && FAULT_FLAGS == '0 && !SLEW_SEL)
        else $error("logic reset left state behind");
    AST_LOCKED_RST: assert property (locked_reg && wr && FRAME.addr == ADDR_MAIN_CFG
        |=> !LOGIC_RESET_CMD)
        else $error("reset command taken while locked");
    AST_LOCKED_CFG: assert property (locked_reg && wr |=>
        $stable(OL_DETECT_DIS) && $stable(OC_PROFILE_SEL) && $stable(PAIR_EVEN) && $stable(PAIR_ODD))
        else $error("configuration changed while locked");
    AST_LOCKED_CLR: assert property (locked_reg && wr && FRAME.addr == ADDR_ERR_CLR && FRAME.data[0]
        ##1 !fault_set[0] |=> !FAULT_FLAGS[0])
        else $error("clear ignored while locked");
    AST_LOCK_READ: assert property (rd && FRAME.addr == ADDR_LOCK_SLEW |=>
        RD_DATA[LOCK_MSB:LOCK_LSB] == ($past(locked_reg) ? LOCK_CODE : UNLOCK_CODE))
        else $error("lock field read back wrong");
    AST_STAT_SAMPLE: assert property (##1 vds_reg == $past(VDS_BELOW_OL))
        else $error("output status not sampled");
    AST_FAULT_ALL: assert property (|FAULT_EVENT |=>
        (FAULT_FLAGS & $past(FAULT_EVENT)) == $past(FAULT_EVENT))
        else $error("channel fault not latched");
    AST_FAULT_HOLD: assert property (clr_reg == '0 |=>
        (FAULT_FLAGS & $past(FAULT_FLAGS)) == $past(FAULT_FLAGS))
        else $error("fault flag dropped without a clear");
    AST_OT_WARN_HOLD: assert property (OT_WARN_FLAG |=> OT_WARN_FLAG)
        else $error("warning flag dropped without reset");
    AST_NO_FRAME: assert property (!FRAME_STB |=>
        $stable(TEST_CURRENT_EN) && $stable(ACTIVE_MODE_REQ) && $stable(SLEW_SEL) && $stable(PAIR_ODD))
        else $error("configuration changed without a frame");
    AST_NO_READ: assert property (!rd |=> !RD_VALID)
        else $error("read answer without a read frame");

    COV_LOCK_UNLOCK: cover property (locked_reg ##[1:20] !locked_reg);
    COV_RESET_CMD: cover property (LOGIC_RESET_CMD);
    COV_CLEAR_FAULT: cover property (FAULT_FLAGS[0] ##1 clr_reg[0] ##1 !FAULT_FLAGS[0]);
    COV_OL_SUMMARY: cover property (OL_SUMMARY);
    COV_LOCKED_CLEAR: cover property (locked_reg && clr_reg != '0);
endmodule : lsd_config_regs

//--- pkg/lsd_pkg.sv
/*
 lsd_pkg: frame layout, register addresses, field positions and reset
 values of the low-side driver configuration bank.
 assumes the serial framer delivers whole 16-bit frames.
*/
package lsd_pkg;
    // frame command codes in bits 15:14
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h1;
    // register addresses, frame bits 13:8
    localparam logic [5:0] ADDR_OL_SRC = 6'h08;
    localparam logic [5:0] ADDR_OUT_STAT = 6'h09;
    localparam logic [5:0] ADDR_MAIN_CFG = 6'h0c;
    localparam logic [5:0] ADDR_ERR_CLR = 6'h0d;
    localparam logic [5:0] ADDR_LOCK_SLEW = 6'h28;
    // main configuration fields
    localparam int BIT_ACT = 7;
    localparam int BIT_RST = 6;
    localparam int BIT_OL_DIS = 5;
    localparam int BIT_OC_PROF = 4;
    localparam int BIT_PAIR_ODD = 1;
    localparam int BIT_PAIR_EVEN = 0;
    // lock and slew fields
    localparam int LOCK_MSB = 7;
    localparam int LOCK_LSB = 5;
    localparam int BIT_OT_WARN = 2;
    localparam int BIT_SLEW = 0;
    localparam logic [2:0] LOCK_CODE = 3'h6;
    localparam logic [2:0] UNLOCK_CODE = 3'h3;
    // reset values
    localparam logic [7:0] RST_OL_SRC = 8'h00;
    localparam logic [7:0] RST_MAIN_CFG = 8'h00;
    localparam logic [7:0] RST_ERR_CLR = 8'h00;
    localparam logic [7:0] RST_LOCK_SLEW = 8'h60;

    typedef struct packed {
        logic [1:0] cmd;
        logic [5:0] addr;
        logic [7:0] data;
    } lsd_frame_t;
endpackage : lsd_pkg

//--- sim/lsd_host_model.sv
/*
 lsd_host_model: serial host stand-in that issues decoded 16-bit frames.
 assumes the bank takes frames on rising MCLK and answers reads one cycle later.
*/
`timescale 1ns/1ps
module lsd_host_model (
    input wire logic MCLK,
    output logic FRAME_STB,
    output lsd_pkg::lsd_frame_t FRAME,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID
);
    import lsd_pkg::*;
    initial begin
        FRAME_STB = 1'b0;
        FRAME = '0;
    end
    // command and address up top, value in the low byte
    task automatic send(input logic [1:0] cmd, input logic [5:0] addr, input logic [7:0] data);
        @(negedge MCLK);
        FRAME_STB = 1'b1;
        FRAME = '{cmd: cmd, addr: addr, data: data};
        @(negedge MCLK);
        FRAME_STB = 1'b0;
        // idle frame inverted so a stale value is never mistaken for live data
        FRAME = ~FRAME;
    endtask : send
    task automatic read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
        int n;
        ok = 1'b0;
        data = 8'h00;
        send(CMD_READ, addr, 8'h00);
        for (n = 0; n < 4 && ok !== 1'b1; n++) begin
            if (RD_VALID === 1'b1) begin
                ok = 1'b1;
                data = RD_DATA;
            end else begin
                @(negedge MCLK);
            end
        end
    endtask : read
endmodule : lsd_host_model

//--- sim/tb_top.sv
/*
 tb_top: self-checking bench for the configuration register bank.
 assumes lsd_host_model drives the frame side; status inputs driven here at falling edges.
*/
`timescale 1ns/1ps
module tb_top;
    import lsd_pkg::*;
    logic MCLK, SRST, FRAME_STB, RD_VALID, ACT, RST_CMD, OL_DIS, OC_SEL, P_EVEN, P_ODD, SLEW, OL_SUM, OT_WARN;
    logic OVERTEMP_EVENT;
    logic [3:0] VDS_BELOW_OL, CH_ON, FAULT_EVENT, TCE, FLAGS;
    logic [7:0] RD_DATA;
    lsd_frame_t FRAME;
    int bad_count = 0;
    int cmp_count = 0;
    always #20 MCLK = ~MCLK;
    lsd_host_model i_lsd_host_model (.MCLK(MCLK), .FRAME_STB(FRAME_STB), .FRAME(FRAME),
        .RD_DATA(RD_DATA), .RD_VALID(RD_VALID));
    lsd_config_regs i_lsd_config_regs (.MCLK(MCLK), .SRST(SRST), .FRAME_STB(FRAME_STB), .FRAME(FRAME),
        .VDS_BELOW_OL(VDS_BELOW_OL), .CH_ON(CH_ON), .FAULT_EVENT(FAULT_EVENT), .OVERTEMP_EVENT(OVERTEMP_EVENT),
        .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .TEST_CURRENT_EN(TCE), .ACTIVE_MODE_REQ(ACT),
        .LOGIC_RESET_CMD(RST_CMD), .OL_DETECT_DIS(OL_DIS), .OC_PROFILE_SEL(OC_SEL), .PAIR_EVEN(P_EVEN),
        .PAIR_ODD(P_ODD), .SLEW_SEL(SLEW), .FAULT_FLAGS(FLAGS), .OL_SUMMARY(OL_SUM), .OT_WARN_FLAG(OT_WARN));
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [5:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_lsd_host_model.read(addr, d, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: no read answer", $time);
            summarize();
        end else begin
            chk(d, exp, $sformatf("read of %h", addr));
        end
    endtask : rd
    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        i_lsd_host_model.send(CMD_WRITE, addr, data);
    endtask : wr
    task automatic pulse(input logic [3:0] ch, input logic ot);
        @(negedge MCLK);
        FAULT_EVENT = ch;
        OVERTEMP_EVENT = ot;
        @(negedge MCLK);
        FAULT_EVENT = 4'h0;
        OVERTEMP_EVENT = 1'b0;
        repeat (2) @(negedge MCLK);
    endtask : pulse
    task automatic t_defaults;
        rd(ADDR_OL_SRC, 8'h00);
        rd(ADDR_OUT_STAT, 8'h00);
        rd(ADDR_MAIN_CFG, 8'h00);
        rd(ADDR_ERR_CLR, 8'h00);
        rd(ADDR_LOCK_SLEW, 8'h60);
        rd(6'h3f, 8'h00);
        chk({2'h0, TCE, SLEW, OT_WARN}, 8'h00, "outputs after reset");
        $display("defaults done");
    endtask : t_defaults
    task automatic t_config;
        wr(ADDR_OL_SRC, 8'hff);
        chk({4'h0, TCE}, 8'h0f, "source enables");
        rd(ADDR_OL_SRC, 8'h0f);
        wr(ADDR_MAIN_CFG, 8'hbf);
        chk({2'h0, RST_CMD, ACT, OL_DIS, OC_SEL, P_ODD, P_EVEN}, 8'h1f, "config outputs");
        rd(ADDR_MAIN_CFG, 8'hb3);
        wr(ADDR_LOCK_SLEW, 8'h61);
        chk({7'h0, SLEW}, 8'h01, "fast slew");
        rd(ADDR_LOCK_SLEW, 8'h61);
        $display("config done");
    endtask : t_config
    task automatic t_status;
        VDS_BELOW_OL = 4'h5;
        CH_ON = 4'h4;
        repeat (2) @(negedge MCLK);
        chk({7'h0, OL_SUM}, 8'h01, "summary set");
        wr(ADDR_OUT_STAT, 8'h00);
        rd(ADDR_OUT_STAT, 8'h05);
        CH_ON = 4'h5;
        repeat (2) @(negedge MCLK);
        chk({7'h0, OL_SUM}, 8'h00, "summary ignores on channels");
        VDS_BELOW_OL = 4'h0;
        CH_ON = 4'h0;
        $display("status done");
    endtask : t_status
    task automatic t_faults;
        pulse(4'h2, 1'b0);
        chk({4'h0, FLAGS}, 8'h0a, "odd pair fault");
        wr(ADDR_ERR_CLR, 8'h0a);
        @(negedge MCLK);
        chk({4'h0, FLAGS}, 8'h00, "faults cleared");
        rd(ADDR_ERR_CLR, 8'h00);
        pulse(4'h1, 1'b0);
        chk({4'h0, FLAGS}, 8'h05, "even pair fault");
        $display("faults done");
    endtask : t_faults
    task automatic t_lock;
        wr(ADDR_LOCK_SLEW, 8'hc1);
        rd(ADDR_LOCK_SLEW, 8'hc1);
        wr(ADDR_OL_SRC, 8'h00);
        chk({4'h0, TCE}, 8'h0f, "locked write dropped");
        wr(ADDR_MAIN_CFG, 8'h40);
        chk({6'h0, RST_CMD, ACT}, 8'h01, "locked reset bit dropped");
        wr(ADDR_LOCK_SLEW, 8'h20);
        rd(ADDR_LOCK_SLEW, 8'hc1);
        wr(ADDR_ERR_CLR, 8'h05);
        @(negedge MCLK);
        chk({4'h0, FLAGS}, 8'h00, "clear while locked");
        wr(ADDR_LOCK_SLEW, 8'h60);
        // slew bit rode on a locked frame, so fast slew stays
        rd(ADDR_LOCK_SLEW, 8'h61);
        wr(ADDR_OL_SRC, 8'h03);
        rd(ADDR_OL_SRC, 8'h03);
        $display("lock done");
    endtask : t_lock
    task automatic t_reset_cmd;
        pulse(4'h0, 1'b1);
        chk({7'h0, OT_WARN}, 8'h01, "warning flag");
        rd(ADDR_LOCK_SLEW, 8'h65);
        wr(ADDR_MAIN_CFG, 8'h40);
        chk({7'h0, RST_CMD}, 8'h01, "reset command");
        @(negedge MCLK);
        chk({RST_CMD, ACT, OT_WARN, P_ODD, TCE}, 8'h00, "state after reset command");
        rd(ADDR_MAIN_CFG, 8'h00);
        $display("reset command done");
    endtask : t_reset_cmd
    initial begin
        MCLK = 1'b0;
        SRST = 1'b1;
        VDS_BELOW_OL = 4'h0;
        CH_ON = 4'h0;
        FAULT_EVENT = 4'h0;
        OVERTEMP_EVENT = 1'b0;
        repeat (3) @(negedge MCLK);
        SRST = 1'b0;
        t_defaults();
        t_config();
        t_status();
        t_faults();
        t_lock();
        t_reset_cmd();
        summarize();
    end
endmodule : tb_top
